// ==== bench/cdb_exec_monitor.sv ====
// checker for the execute block ports
`timescale 1ns/1ns
`include "exec_defs.vh"
module cdb_exec_mon (
    // clock, reset and single-bit ports
    input wire        clk_sys, rst_n, instr_valid, file_we_q, flush_q, busy_q,
    // instruction, data and core state
    input wire [11:0] instr,
    input wire [7:0]  file_rdata, file_wdata_q, wreg_q, status_q,
    input wire [10:0] program_counter_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire tk  = instr_valid && !busy_q;
    wire inv = tk && instr[11:6] == `OPC_INVERT_F;
    wire dec = tk && instr[11:6] == `OPC_DEC_F;
    wire dsk = tk && instr[11:6] == `OPC_DEC_SKIP_Z;
    wire jmp = tk && instr[11:9] == `OPC_JUMP_ABS;
    a_invert_result: assert property (inv |=>
        (file_we_q ? file_wdata_q : wreg_q) == ~$past(file_rdata)) else $error("bad invert");
    a_dest_select: assert property (inv || dec |=> file_we_q == $past(instr[5]))
        else $error("bad destination");
    a_dec_zero: assert property (dec |=> status_q[2] == ($past(file_rdata) == 8'h01))
        else $error("bad zero flag");
    a_skip_flags: assert property (dsk |=> $stable(status_q))
        else $error("skip changed status");
    a_skip_discard: assert property (dsk && file_rdata == 8'h01 |=> flush_q && busy_q ##1 !busy_q)
        else $error("bad skip");
    a_jump_target: assert property (jmp |=>
        program_counter_q == {$past(status_q[6:5]), $past(instr[8:0])}) else $error("bad jump");
    a_jump_cycles: assert property (jmp |=> flush_q && busy_q && $stable(status_q) ##1 !busy_q)
        else $error("bad jump timing");
    a_single_cycle: assert property (inv || dec || dsk && file_rdata != 8'h01 |=>
        !busy_q && !flush_q) else $error("not single cycle");
endmodule
bind cdb_exec cdb_exec_mon u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .file_we_q(file_we_q),
    .flush_q(flush_q), .busy_q(busy_q), .instr(instr), .file_rdata(file_rdata),
    .file_wdata_q(file_wdata_q), .wreg_q(wreg_q), .status_q(status_q),
    .program_counter_q(program_counter_q));

// ==== bench/tb_cdb_exec.sv ====
// self-checking bench for the execute block
`timescale 1ns/1ns
module tb_cdb_exec;
    logic        clk_sys = 0, rst_n = 0, instr_valid = 0;
    logic [11:0] instr = 0;
    logic [7:0]  file_rdata = 0;
    wire  [4:0]  file_addr_q;
    wire  [7:0]  file_wdata_q, wreg_q, status_q;
    wire  [10:0] program_counter_q;
    wire         file_we_q, flush_q, busy_q;
    int          n_mismatch = 0, checks_done = 0, pc = 'h7ff, w = 0, z = 0;
    logic [5:0]  ops [3] = '{6'h09, 6'h03, 6'h0b};
    int          wr_q [$];
    always #50 clk_sys = ~clk_sys;
    cdb_exec u_cdb_exec (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr),
        .instr_valid(instr_valid), .file_rdata(file_rdata), .file_addr_q(file_addr_q),
        .file_wdata_q(file_wdata_q), .file_we_q(file_we_q), .wreg_q(wreg_q),
        .status_q(status_q), .program_counter_q(program_counter_q), .flush_q(flush_q),
        .busy_q(busy_q));
    task chk_data(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: data got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_pc(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: pc got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_ctl(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: strobe got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // present one word at a falling edge, check one cycle later
    task run(input logic [11:0] op, input logic [7:0] rd);
        int r, d, sk;
        instr = op; instr_valid = 1; file_rdata = rd;
        d = op[5]; sk = 0; r = 0; pc = (pc + 1) & 'h7ff;
        case (op[11:6])
            6'h09: begin r = ~rd & 255; z = r == 0; end
            6'h03: begin r = (rd - 1) & 255; z = r == 0; end
            6'h0b: begin r = (rd - 1) & 255; sk = r == 0; end
            default: begin d = 2; sk = 1; pc = (((8'h18 >> 5) & 3) << 9) | op[8:0]; end
        endcase
        if (d == 0) w = r;
        if (d == 1) wr_q.push_back({op[4:0], r[7:0]});
        @(negedge clk_sys);
        chk_data(wreg_q, w);
        chk_ctl(file_we_q, d == 1);
        if (d == 1) chk_data({file_addr_q, file_wdata_q}, wr_q.pop_front());
        chk_data(status_q, 8'h18 | (z << 2));
        chk_pc(program_counter_q, pc);
        chk_ctl({flush_q, busy_q}, sk ? 3 : 0);
        if (sk) begin
            // discarded word: ignored, runs as idle_op
            instr = {ops[$urandom % 3], 6'($urandom)};
            instr_valid = 1'($urandom);
            file_rdata = 8'($urandom);
            pc = (pc + instr_valid) & 'h7ff;
            @(negedge clk_sys);
            chk_ctl({flush_q, busy_q, file_we_q}, 0);
            chk_data(wreg_q, w);
            chk_data(status_q, 8'h18 | (z << 2));
            chk_pc(program_counter_q, pc);
        end
    endtask
    initial begin
        void'($urandom(32'h60dc));
        repeat (12) @(negedge clk_sys);
        rst_n = 1;
        @(negedge clk_sys);
        run(12'h263, 8'h13);
        run(12'h240, 8'hff);
        run(12'h0e7, 8'h01);
        run(12'hbff, 8'h00);
        for (int i = 0; i < 60; i++) begin
            if (i % 7 == 0) run(12'ha00 | 9'($urandom), 8'($urandom));
            run({ops[i % 3], 6'($urandom)}, i % 4 ? 8'($urandom) : 8'h01);
        end
        summarize;
    end
    initial begin
        #100000;
        n_mismatch++;
        summarize;
    end
endmodule

// ==== common/exec_defs.vh ====
// opcode encodings, field positions, status bits and reset values for the executor
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

`define OPC_INVERT_F     6'h09
`define OPC_DEC_F        6'h03
`define OPC_DEC_SKIP_Z   6'h0b
`define OPC_JUMP_ABS     3'h5
`define OPC6_MSB         11
`define OPC6_LSB         6
`define OPC3_MSB         11
`define OPC3_LSB         9
`define DEST_BIT         5
`define FADDR_MSB        4
`define FADDR_LSB        0
`define LIT_MSB          8
`define LIT_LSB          0
`define STAT_PAGE_MSB    6
`define STAT_PAGE_LSB    5
`define STAT_ZERO_BIT    2
`define WREG_RESET       8'h00
`define STAT_RESET       8'h18
`define PC_RESET         11'h7ff

`endif

// ==== rtl/cdb_exec.v ====
// execute stage for invert, decrement, decrement-skip and absolute jump
`timescale 1ns/1ns
`include "exec_defs.vh"

module cdb_exec (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // fetched instruction
    input  wire [11:0] instr,
    input  wire        instr_valid,
    // file register read port
    input  wire [7:0]  file_rdata,
    // file register write port
    output reg  [4:0]  file_addr_q,
    output reg  [7:0]  file_wdata_q,
    output reg         file_we_q,
    // core state
    output reg  [7:0]  wreg_q,
    output reg  [7:0]  status_q,
    output reg  [10:0] program_counter_q,
    output reg         flush_q,
    output reg         busy_q
);

    // execution states
    localparam ST_RUN   = 1'b0;
    localparam ST_FLUSH = 1'b1;

    // decoded fields
    wire        is_invert;
    wire        is_dec;
    wire        is_dec_skip;
    wire        is_jump;
    wire        dest_file;
    wire [4:0]  faddr;
    wire [8:0]  literal;
    wire [7:0]  inv_bits;

    // state and next values
    reg         state_q;
    reg         state_d;
    reg  [7:0]  result;
    reg         take;
    reg         reg_op;
    reg         res_zero;
    reg         busy_d;
    reg         flush_d;
    reg  [4:0]  file_addr_d;
    reg  [7:0]  file_wdata_d;
    reg         file_we_d;
    reg  [7:0]  wreg_d;
    reg  [7:0]  status_d;
    reg  [10:0] program_counter_d;

    // true when a byte is all zeros
    function zero_byte;
        input [7:0] v;
        begin
            zero_byte = (v == 8'h00);
        end
    endfunction

    // true for the three file register opcodes
    function file_op;
        input inv;
        input dec;
        input dsk;
        begin
            file_op = inv | dec | dsk;
        end
    endfunction

    op_decode u_dec (
        .instr       (instr),
        .is_invert   (is_invert),
        .is_dec      (is_dec),
        .is_dec_skip (is_dec_skip),
        .is_jump     (is_jump),
        .dest_file   (dest_file),
        .file_addr   (faddr),
        .literal     (literal)
    );

    // bitwise inversion of the addressed file register
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_inv
            assign inv_bits[gi] = ~file_rdata[gi];
        end
    endgenerate

    // operation result
    always @* begin
        take   = instr_valid && (state_q == ST_RUN);
        reg_op = file_op(is_invert, is_dec, is_dec_skip);
        result = 8'h00;
        if (is_invert) begin
            result = inv_bits;
        end else if (is_dec || is_dec_skip) begin
            result = file_rdata - 8'h01;
        end
        res_zero = zero_byte(result);
    end

    // two-cycle sequencing
    always @* begin
        state_d = ST_RUN;
        case (state_q)
            ST_RUN: begin
                if (take && (is_jump || (is_dec_skip && res_zero))) begin
                    state_d = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        busy_d  = (state_d == ST_FLUSH);
        flush_d = take && (is_jump || (is_dec_skip && res_zero));
    end

    // file register write port
    always @* begin
        file_addr_d  = file_addr_q;
        file_wdata_d = file_wdata_q;
        file_we_d    = 1'b0;
        if (take && reg_op && dest_file) begin
            file_addr_d  = faddr;
            file_wdata_d = result;
            file_we_d    = 1'b1;
        end
    end

    // working register
    always @* begin
        wreg_d = wreg_q;
        if (take && reg_op && !dest_file) begin
            wreg_d = result;
        end
    end

    // zero flag, left alone by decrement-skip and jump
    always @* begin
        status_d = status_q;
        if (take && (is_invert || is_dec)) begin
            status_d[`STAT_ZERO_BIT] = res_zero;
        end
    end

    // program counter
    always @* begin
        program_counter_d = program_counter_q;
        if (take) begin
            if (is_jump) begin
                program_counter_d = {status_q[`STAT_PAGE_MSB:`STAT_PAGE_LSB],
                                     literal};
            end else begin
                program_counter_d = program_counter_q + 11'h001;
            end
        end else if ((state_q == ST_FLUSH) && instr_valid) begin
            // discarded word executes as idle_op
            program_counter_d = program_counter_q + 11'h001;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            busy_q  <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q  <= busy_d;
            flush_q <= flush_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            file_addr_q  <= 5'h00;
            file_wdata_q <= 8'h00;
            file_we_q    <= 1'b0;
        end else begin
            file_addr_q  <= file_addr_d;
            file_wdata_q <= file_wdata_d;
            file_we_q    <= file_we_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wreg_q <= `WREG_RESET;
        end else begin
            wreg_q <= wreg_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `STAT_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            program_counter_q <= `PC_RESET;
        end else begin
            program_counter_q <= program_counter_d;
        end
    end

endmodule

// ==== rtl/op_decode.v ====
// instruction word decoder for the four handled opcodes
`timescale 1ns/1ns
`include "exec_defs.vh"

module op_decode (
    // instruction word
    input  wire [11:0] instr,
    // decoded strobes and fields
    output wire        is_invert,
    output wire        is_dec,
    output wire        is_dec_skip,
    output wire        is_jump,
    output wire        dest_file,
    output wire [4:0]  file_addr,
    output wire [8:0]  literal
);

    assign is_invert   = (instr[`OPC6_MSB:`OPC6_LSB] == `OPC_INVERT_F);
    assign is_dec      = (instr[`OPC6_MSB:`OPC6_LSB] == `OPC_DEC_F);
    assign is_dec_skip = (instr[`OPC6_MSB:`OPC6_LSB] == `OPC_DEC_SKIP_Z);
    assign is_jump     = (instr[`OPC3_MSB:`OPC3_LSB] == `OPC_JUMP_ABS);
    assign dest_file   = instr[`DEST_BIT];
    assign file_addr   = instr[`FADDR_MSB:`FADDR_LSB];
    assign literal     = instr[`LIT_MSB:`LIT_LSB];

endmodule
